// *** pcf_top.sv ***
// Pack configuration decode, status flags and power mode logic
`timescale 1ns/1ps
`include "pcf_cfg.svh"
module pcf_top (
	input  wire logic              CLK,
	input  wire logic              RST_N,
	input  wire logic              CFG_WE,
	input  wire logic [15:0]       CFG_WDATA,
	output logic      [15:0]       CFG_RDATA,
	input  wire logic              MEAS_VALID,
	input  wire pcf_pkg::pcf_meas_t MEAS,
	input  wire pcf_pkg::pcf_thr_t THR,
	input  wire logic              COMM_ACT,
	input  wire logic              IO_ACT,
	input  wire logic              HIB_REQ,
	input  wire logic              SET_SHUTDOWN,
	input  wire logic              CLEAR_SHUTDOWN,
	input  wire logic              SENSE_POS_TRIP,
	input  wire logic              SENSE_NEG_TRIP,
	output logic [`PCF_FLAG_W-1:0] FLAGS,
	output pcf_pkg::pcf_mode_t     MODE,
	output logic                   WAKE_EVENT,
	output logic                   RESERVE_COMP_ENABLE_EN,
	output logic                   ADC_GND_ALT,
	output logic [2:0]             WAKE_SEL,
	output logic                   RA_STEP_EN,
	output logic                   REMCAP_LOAD,
	output logic                   EXT_TEMP_SEL,
	output logic                   SHUTDOWN_EN,
	output logic                   SD_PIN_OUT,
	output logic                   SD_PIN_OE_N
);
	logic [15:0]            cfg_r;
	logic [15:0]            cfg_nxt;
	logic [`PCF_FLAG_W-1:0] flags_r;
	logic [`PCF_FLAG_W-1:0] flags_nxt;
	pcf_pkg::pcf_mode_t     mode_r;
	pcf_pkg::pcf_mode_t     mode_nxt;
	logic                   sd_en_r;
	logic [1:0]             taper_cnt_r;
	logic                   pullup_r;
	logic                   pullup_taken_r;
	logic                   wake_r;
	logic                   remcap_r;
	logic                   otc_cond;
	logic                   otd_cond;
	logic                   otc_met;
	logic                   otd_met;
	logic                   taper_ok;
	logic                   taper_done;
	logic                   in_inh_band;
	logic                   sd_active;
	logic                   sense_on;

	// Configuration word write path, whole 16-bit word in one write
	always_comb begin
		cfg_nxt = cfg_r;
		if (CFG_WE) begin
			cfg_nxt = CFG_WDATA; // [R1]
		end
	end

	// Nonvolatile-style configuration storage with documented defaults
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			cfg_r <= `PCF_CFG_RESET; // [R1] [R2] [R3] [R4] [R5] [R6] [R7] [R8] [R9] [R10] [R11]
		end else begin
			cfg_r <= cfg_nxt;
		end
	end

	// Pull-up setting is adopted once, at the first edge after reset release; later writes wait for reset
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			pullup_r       <= 1'b0;
			pullup_taken_r <= 1'b0;
		end else if (!pullup_taken_r) begin
			pullup_r       <= cfg_r[`PCF_B_PULLUP]; // [R8]
			pullup_taken_r <= 1'b1;
		end
	end

	// Shutdown feature status, set by enable bit or command
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			sd_en_r <= 1'b1;
		end else if (SET_SHUTDOWN || (CFG_WE && CFG_WDATA[`PCF_B_SD_EN])) begin
			sd_en_r <= 1'b1; // [R10]
		end else if (CLEAR_SHUTDOWN || (CFG_WE && !CFG_WDATA[`PCF_B_SD_EN])) begin
			sd_en_r <= 1'b0;
		end
	end

	// Over-temperature conditions
	assign otc_cond = (MEAS.temp >= THR.charge_heat_limit) && (MEAS.avg_cur > THR.chg_thr);
	assign otd_cond = (MEAS.temp >= THR.discharge_heat_limit) && (MEAS.avg_cur <= -THR.dsg_thr);

	pcf_hold u_hold_chg (
		.CLK   (CLK),
		.RST_N (RST_N),
		.tick  (MEAS_VALID),
		.cond  (otc_cond),
		.hold  (THR.charge_heat_limit_time),
		.met   (otc_met)
	);

	pcf_hold u_hold_dsg (
		.CLK   (CLK),
		.RST_N (RST_N),
		.tick  (MEAS_VALID),
		.cond  (otd_cond),
		.hold  (THR.discharge_heat_limit_time),
		.met   (otd_met)
	);

	// Taper qualification for one window
	assign taper_ok = (MEAS.avg_cur < THR.taper_cur) && (MEAS.dcap > `PCF_MIN_DCAP) &&
		({1'b0, MEAS.volt} > ({1'b0, THR.chg_volt} - {1'b0, THR.taper_volt}));

	// Consecutive taper windows
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			taper_cnt_r <= 2'h0;
		end else if (MEAS_VALID) begin
			if (!taper_ok) begin
				taper_cnt_r <= 2'h0;
			end else if (taper_cnt_r != `PCF_TAPER_WINDOWS) begin
				taper_cnt_r <= taper_cnt_r + 2'h1; // [R15]
			end
		end
	end

	assign taper_done = taper_ok && (taper_cnt_r + 2'h1 >= `PCF_TAPER_WINDOWS); // [R15]
	assign in_inh_band = (MEAS.temp >= THR.inh_lo + THR.hys) && (MEAS.temp <= THR.inh_hi - THR.hys);

	// Next flag word, built whole from one measurement set
	always_comb begin
		flags_nxt = flags_r;
		if (otc_met) begin
			flags_nxt[`PCF_F_OTC] = 1'b1; // [R12]
		end else if (MEAS.temp <= THR.charge_heat_limit_rec || THR.charge_heat_limit_time == 8'h00) begin
			flags_nxt[`PCF_F_OTC] = 1'b0; // [R12] [R14]
		end
		if (otd_met) begin
			flags_nxt[`PCF_F_OTD] = 1'b1; // [R13]
		end else if (MEAS.temp <= THR.discharge_heat_limit_rec || THR.discharge_heat_limit_time == 8'h00) begin
			flags_nxt[`PCF_F_OTD] = 1'b0; // [R13] [R14]
		end
		if (MEAS.temp < THR.inh_lo || MEAS.temp > THR.inh_hi) begin
			flags_nxt[`PCF_F_INH] = 1'b1; // [R18]
		end else if (in_inh_band) begin
			flags_nxt[`PCF_F_INH] = 1'b0; // [R18]
		end
		if (MEAS.temp < THR.sus_lo || MEAS.temp > THR.sus_hi) begin
			flags_nxt[`PCF_F_SUSP] = 1'b1; // [R19]
		end else if (in_inh_band) begin
			flags_nxt[`PCF_F_SUSP] = 1'b0; // [R19] [R20]
		end
		if (taper_done) begin
			flags_nxt[`PCF_F_CHG] = 1'b0; // [R15]
		end else if (MEAS.avg_cur > THR.chg_thr) begin
			flags_nxt[`PCF_F_CHG] = 1'b1;
		end
		if (THR.terminate_alarm_set_level == `PCF_LEVEL_OFF) begin
			flags_nxt[`PCF_F_TERM] = taper_done || (flags_r[`PCF_F_TERM] && !(MEAS.avg_cur > THR.chg_thr)); // [R16]
		end else begin
			flags_nxt[`PCF_F_TERM] = taper_done || (THR.rsoc >= THR.terminate_alarm_set_level);
		end
		if (THR.full_charge_set_level == `PCF_LEVEL_OFF) begin
			flags_nxt[`PCF_F_FULL] = taper_done || (flags_r[`PCF_F_FULL] && !(MEAS.avg_cur > THR.chg_thr)); // [R17]
		end else begin
			flags_nxt[`PCF_F_FULL] = taper_done || (THR.rsoc >= THR.full_charge_set_level);
		end
		flags_nxt[`PCF_FLAG_W-1] = 1'b0;
	end

	// Flags register, updated only when a measurement set lands
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			flags_r <= {`PCF_FLAG_W{1'b0}};
		end else if (MEAS_VALID) begin
			flags_r <= flags_nxt; // [R25]
		end
	end

	// Remaining-capacity reload pulse on valid termination
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			remcap_r <= 1'b0;
		end else begin
			remcap_r <= MEAS_VALID && taper_done && cfg_r[`PCF_B_REMCAP_FROM_FULLCAP]; // [R7]
		end
	end

	// Wake comparator, disabled when both sense selects are clear
	assign sense_on = cfg_r[`PCF_B_RSNS_HI] || cfg_r[`PCF_B_RSNS_LO];
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			wake_r <= 1'b0;
		end else begin
			wake_r <= sense_on && (SENSE_POS_TRIP || SENSE_NEG_TRIP); // [R23]
		end
	end

	// Power mode selection
	always_comb begin
		mode_nxt = mode_r;
		case (mode_r)
			pcf_pkg::PM_NORMAL: begin
				if (HIB_REQ) begin
					mode_nxt = pcf_pkg::PM_HIBERNATE; // [R21]
				end else if (cfg_r[`PCF_B_SLEEP] && MEAS.avg_cur < THR.sleep_cur) begin
					mode_nxt = pcf_pkg::PM_SLEEP; // [R6] [R22]
				end
			end
			pcf_pkg::PM_SLEEP: begin
				if (!cfg_r[`PCF_B_SLEEP] || !(MEAS.avg_cur < THR.sleep_cur) || wake_r) begin
					mode_nxt = pcf_pkg::PM_NORMAL; // [R22] [R23]
				end else if (HIB_REQ) begin
					mode_nxt = pcf_pkg::PM_HIBERNATE;
				end
			end
			pcf_pkg::PM_HIBERNATE: begin
				if (COMM_ACT || IO_ACT) begin
					mode_nxt = pcf_pkg::PM_NORMAL; // [R21]
				end
			end
			default: begin
				mode_nxt = pcf_pkg::PM_NORMAL;
			end
		endcase
	end

	// Power mode register
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			mode_r <= pcf_pkg::PM_NORMAL;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	assign sd_active = (mode_r == pcf_pkg::PM_HIBERNATE) && sd_en_r; // [R24]

	// Shutdown pin drive: level and enable from pull-up and polarity
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			SD_PIN_OUT  <= 1'b0;
			SD_PIN_OE_N <= 1'b1;
		end else if (sd_active) begin
			SD_PIN_OUT  <= cfg_r[`PCF_B_POL]; // [R9] [R24]
			SD_PIN_OE_N <= cfg_r[`PCF_B_POL] && !pullup_r; // [R8]
		end else begin
			SD_PIN_OUT  <= !cfg_r[`PCF_B_POL]; // [R24]
			SD_PIN_OE_N <= !(pullup_r || cfg_r[`PCF_B_POL]); // [R8] [R9]
		end
	end

	// Registered copies of decoded configuration and status
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			CFG_RDATA    <= `PCF_CFG_RESET;
			FLAGS        <= {`PCF_FLAG_W{1'b0}};
			MODE         <= pcf_pkg::PM_NORMAL;
			WAKE_EVENT   <= 1'b0;
			RESERVE_COMP_ENABLE_EN    <= 1'b0;
			ADC_GND_ALT  <= 1'b0;
			WAKE_SEL     <= 3'h1;
			RA_STEP_EN   <= 1'b1;
			REMCAP_LOAD  <= 1'b0;
			EXT_TEMP_SEL <= 1'b1;
			SHUTDOWN_EN  <= 1'b1;
		end else begin
			CFG_RDATA    <= cfg_r;
			FLAGS        <= flags_r;
			MODE         <= mode_r;
			WAKE_EVENT   <= wake_r;
			RESERVE_COMP_ENABLE_EN    <= cfg_r[`PCF_B_RESERVE_COMP_ENABLE]; // [R2]
			ADC_GND_ALT  <= cfg_r[`PCF_B_ADC_GROUND_SELECT]; // [R3]
			WAKE_SEL     <= {cfg_r[`PCF_B_WAKE_RANGE], cfg_r[`PCF_B_RSNS_HI], cfg_r[`PCF_B_RSNS_LO]}; // [R4]
			RA_STEP_EN   <= cfg_r[`PCF_B_RA_STEP]; // [R5]
			REMCAP_LOAD  <= remcap_r; // [R7]
			EXT_TEMP_SEL <= cfg_r[`PCF_B_EXTERNAL_THERMISTOR_SELECT]; // [R11]
			SHUTDOWN_EN  <= sd_en_r; // [R10]
		end
	end
endmodule

// *** pcf_cfg.svh ***
// Constants for the pack configuration and status flag block
// Summary of operation
// [R1] Hold 16-bit pack configuration word, two bytes
// [R2] Reserve compensation enable, resets to zero
// [R3] ADC ground select: clear main, set alternate
// [R4] Wake range and sense selects default 0/0/1
// [R5] Resistance step enable, default set
// [R6] Sleep permit bit; clear means never sleep
// [R7] Load remaining from full on termination
// [R8] Shutdown pin pull-up makes pin push-pull
// [R9] Shutdown polarity: clear low, set high
// [R10] Shutdown feature enable, default set
// [R11] Temperature source: set external, clear internal
// [R12] Charge over-temperature set with hold, recovery clear
// [R13] Discharge over-temperature set with hold, recovery clear
// [R14] Zero hold time disables that check
// [R15] Termination: taper current twice, capacity, voltage
// [R16] Alarm level -1: terminate on taper
// [R17] Full level -1: full only on taper
// [R18] Inhibit flag outside window, clears with hysteresis
// [R19] Suspend flag outside window, clears inside inhibit
// [R20] Host keeps inhibit window inside suspend window
// [R21] Normal, sleep, hibernate modes; wake on activity
// [R22] Sleep when permitted and current below level
// [R23] Wake event on sense threshold breach; 00 disables
// [R24] Shutdown state only in hibernate with enable
// [R25] Flags re-evaluated per measurement set, atomically
`ifndef PCF_CFG_SVH
`define PCF_CFG_SVH
`define PCF_CFG_RESET        16'h0177
`define PCF_B_RESERVE_COMP_ENABLE         15
`define PCF_B_ADC_GROUND_SELECT         11
`define PCF_B_WAKE_RANGE     10
`define PCF_B_RSNS_HI        9
`define PCF_B_RSNS_LO        8
`define PCF_B_RA_STEP        6
`define PCF_B_SLEEP          5
`define PCF_B_REMCAP_FROM_FULLCAP          4
`define PCF_B_PULLUP         3
`define PCF_B_POL            2
`define PCF_B_SD_EN          1
`define PCF_B_EXTERNAL_THERMISTOR_SELECT          0
`define PCF_TAPER_WINDOWS    2'h2
`define PCF_MIN_DCAP         16'h0019
`define PCF_LEVEL_OFF        16'hFFFF
`define PCF_FLAG_W           8
`define PCF_F_OTC            0
`define PCF_F_OTD            1
`define PCF_F_INH            2
`define PCF_F_SUSP           3
`define PCF_F_CHG            4
`define PCF_F_TERM           5
`define PCF_F_FULL           6
`endif

// *** pcf_pkg.sv ***
// Types for the pack configuration and status flag block
package pcf_pkg;
	typedef enum logic [1:0] {PM_NORMAL, PM_SLEEP, PM_HIBERNATE} pcf_mode_t;
	typedef struct packed {
		logic signed [15:0] temp;
		logic signed [15:0] avg_cur;
		logic        [15:0] volt;
		logic        [15:0] dcap;
	} pcf_meas_t;
	typedef struct packed {
		logic signed [15:0] charge_heat_limit;
		logic signed [15:0] charge_heat_limit_rec;
		logic        [7:0]  charge_heat_limit_time;
		logic signed [15:0] discharge_heat_limit;
		logic signed [15:0] discharge_heat_limit_rec;
		logic        [7:0]  discharge_heat_limit_time;
		logic signed [15:0] chg_thr;
		logic signed [15:0] dsg_thr;
		logic signed [15:0] inh_lo;
		logic signed [15:0] inh_hi;
		logic signed [15:0] sus_lo;
		logic signed [15:0] sus_hi;
		logic signed [15:0] hys;
		logic signed [15:0] taper_cur;
		logic        [15:0] chg_volt;
		logic        [15:0] taper_volt;
		logic signed [15:0] terminate_alarm_set_level;
		logic signed [15:0] full_charge_set_level;
		logic        [15:0] rsoc;
		logic        [15:0] sleep_cur;
	} pcf_thr_t;
endpackage

// *** pcf_hold.sv ***
// Hold-time counter for one over-temperature check
`timescale 1ns/1ps
module pcf_hold (
	input  wire logic       CLK,
	input  wire logic       RST_N,
	input  wire logic       tick,
	input  wire logic       cond,
	input  wire logic [7:0] hold,
	output logic            met
);
	logic [7:0] cnt_r;

	// Count measurement sets in which the condition holds; zero hold never fires
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			cnt_r <= 8'h00;
		end else if (tick) begin
			if (!cond || hold == 8'h00) begin // [R14]
				cnt_r <= 8'h00;
			end else if (cnt_r != 8'hFF) begin
				cnt_r <= cnt_r + 8'h01;
			end
		end
	end

	// Compare against hold minus one so the match comes in the set that completes the hold count
	assign met = (hold != 8'h00) && cond && (cnt_r >= hold - 8'h01); // [R12] [R13] [R14]
endmodule

// *** pcf_monitor.sv ***
// Checker on the ports of the pack configuration and status flag block
`timescale 1ns/1ps
`include "pcf_cfg.svh"
module pcf_monitor (
	input wire logic                   CLK,
	input wire logic                   RST_N,
	input wire logic                   CFG_WE,
	input wire logic [15:0]            CFG_WDATA,
	input wire logic [15:0]            CFG_RDATA,
	input wire logic                   MEAS_VALID,
	input wire pcf_pkg::pcf_meas_t     MEAS,
	input wire pcf_pkg::pcf_thr_t      THR,
	input wire logic                   SENSE_POS_TRIP,
	input wire logic                   SENSE_NEG_TRIP,
	input wire logic [`PCF_FLAG_W-1:0] FLAGS,
	input wire pcf_pkg::pcf_mode_t     MODE,
	input wire logic                   WAKE_EVENT,
	input wire logic [2:0]             WAKE_SEL,
	input wire logic                   REMCAP_LOAD,
	input wire logic                   SD_PIN_OUT,
	input wire logic                   SD_PIN_OE_N
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);
	// Stored word, sleep permit, wake, flags and shutdown pin relations
	property p_cfg;
		CFG_WE |-> ##2 CFG_RDATA == $past(CFG_WDATA, 2);
	endproperty
	a_cfg: assert property (p_cfg) else $error("config readback wrong");
	property p_sleep;
		!CFG_RDATA[`PCF_B_SLEEP] [*4] |-> MODE != pcf_pkg::PM_SLEEP;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep while not permitted");
	property p_wake_on;
		(SENSE_POS_TRIP || SENSE_NEG_TRIP) && WAKE_SEL[1:0] != 2'h0 |-> ##2 WAKE_EVENT;
	endproperty
	a_wake_on: assert property (p_wake_on) else $error("wake event missing");
	property p_wake_off;
		WAKE_SEL[1:0] == 2'h0 [*3] |-> !WAKE_EVENT;
	endproperty
	a_wake_off: assert property (p_wake_off) else $error("wake event while disabled");
	property p_ot_off;
		THR.discharge_heat_limit_time == 8'h00 |-> !FLAGS[`PCF_F_OTD];
	endproperty
	a_ot_off: assert property (p_ot_off) else $error("disabled check raised flag");
	property p_inh;
		MEAS_VALID && (MEAS.temp < THR.inh_lo || MEAS.temp > THR.inh_hi) |-> ##2 FLAGS[`PCF_F_INH];
	endproperty
	a_inh: assert property (p_inh) else $error("inhibit flag missing");
	property p_upd;
		$changed(FLAGS) |-> $past(MEAS_VALID, 2);
	endproperty
	a_upd: assert property (p_upd) else $error("flags moved without measurement");
	property p_remcap;
		REMCAP_LOAD |-> CFG_RDATA[`PCF_B_REMCAP_FROM_FULLCAP] && $past(MEAS_VALID, 2);
	endproperty
	a_remcap: assert property (p_remcap) else $error("stray capacity load");
	property p_sd;
		$past(MODE) != pcf_pkg::PM_HIBERNATE && MODE != pcf_pkg::PM_HIBERNATE && $stable(CFG_RDATA)
			|-> SD_PIN_OE_N || SD_PIN_OUT != CFG_RDATA[`PCF_B_POL];
	endproperty
	a_sd: assert property (p_sd) else $error("shutdown state outside hibernate");
	c_sleep: cover property (MODE == pcf_pkg::PM_SLEEP);
	c_otc: cover property (FLAGS[`PCF_F_OTC]);
	c_load: cover property (REMCAP_LOAD);
endmodule

bind pcf_top pcf_monitor i_pcf_monitor (
	.CLK            (CLK),
	.RST_N          (RST_N),
	.CFG_WE         (CFG_WE),
	.CFG_WDATA      (CFG_WDATA),
	.CFG_RDATA      (CFG_RDATA),
	.MEAS_VALID     (MEAS_VALID),
	.MEAS           (MEAS),
	.THR            (THR),
	.SENSE_POS_TRIP (SENSE_POS_TRIP),
	.SENSE_NEG_TRIP (SENSE_NEG_TRIP),
	.FLAGS          (FLAGS),
	.MODE           (MODE),
	.WAKE_EVENT     (WAKE_EVENT),
	.WAKE_SEL       (WAKE_SEL),
	.REMCAP_LOAD    (REMCAP_LOAD),
	.SD_PIN_OUT     (SD_PIN_OUT),
	.SD_PIN_OE_N    (SD_PIN_OE_N)
);

// *** pcf_host.sv ***
// Host model that programs the gauge thresholds
`timescale 1ns/1ps
module pcf_host (
	output pcf_pkg::pcf_thr_t THR
);
	// Static thresholds; inhibit band kept inside suspend band
	assign THR = '{16'h01C2, 16'h0190, 8'h02,
		16'h01F4, 16'h01C2, 8'h00,
		16'h000A, 16'h000A,
		16'h0000, 16'h0190, 16'hFFCE, 16'h01F4, 16'h0014,
		16'h0064, 16'h1068, 16'h0064,
		16'hFFFF, 16'hFFFF,
		16'h0032, 16'h0014};
endmodule

// *** test_pcf_top.sv ***
// Self-checking bench for the pack configuration and flag block
`timescale 1ns/1ps
`include "pcf_cfg.svh"
module test_pcf_top;
	logic                   CLK, RST_N, CFG_WE, MEAS_VALID, COMM_ACT, IO_ACT, HIB_REQ, SET_SHUTDOWN;
	logic                   CLEAR_SHUTDOWN, SENSE_POS_TRIP, SENSE_NEG_TRIP, WAKE_EVENT, RESERVE_COMP_ENABLE_EN;
	logic                   ADC_GND_ALT, RA_STEP_EN, REMCAP_LOAD, EXT_TEMP_SEL, SHUTDOWN_EN;
	logic                   SD_PIN_OUT, SD_PIN_OE_N;
	logic [15:0]            CFG_WDATA, CFG_RDATA;
	logic [2:0]             WAKE_SEL;
	logic [`PCF_FLAG_W-1:0] FLAGS;
	pcf_pkg::pcf_meas_t     MEAS;
	pcf_pkg::pcf_thr_t      THR;
	pcf_pkg::pcf_mode_t     MODE;
	logic                   load_seen;
	int                     err_total, checks;

	pcf_host i_pcf_host (.THR(THR));
	pcf_top i_pcf_top (.*);

	// Free-running clock
	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end

	// Remember any capacity reload pulse, which is gone before a compare can look
	always @(posedge CLK) begin
		if (!RST_N) begin
			load_seen <= 1'b0;
		end else if (REMCAP_LOAD) begin
			load_seen <= 1'b1;
		end
	end

	task automatic final_report();
		if (err_total == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Bounded wait for a power mode
	task automatic wait_mode(input pcf_pkg::pcf_mode_t m);
		int n;
		n = 0;
		checks++;
		while (MODE !== m && n < 20) begin
			@(negedge CLK);
			n++;
		end
		if (MODE !== m) begin
			err_total++;
			$display("[FAIL] %0t mode not reached", $time);
			final_report();
		end
	endtask

	task automatic wr(input logic [15:0] d);
		@(negedge CLK);
		CFG_WE = 1'b1;
		CFG_WDATA = d;
		@(negedge CLK) CFG_WE = 1'b0;
		repeat (2) @(negedge CLK);
	endtask

	// One measurement set: temperature, current, voltage, capacity change
	task automatic meas(input logic [15:0] t, input logic [15:0] c, input logic [15:0] d);
		@(negedge CLK);
		MEAS = {t, c, 16'h1036, d};
		MEAS_VALID = 1'b1;
		@(negedge CLK) MEAS_VALID = 1'b0;
		repeat (2) @(negedge CLK);
	endtask

	initial begin
		{CFG_WE, MEAS_VALID, COMM_ACT, IO_ACT, HIB_REQ, SET_SHUTDOWN, CLEAR_SHUTDOWN} = '0;
		{SENSE_POS_TRIP, SENSE_NEG_TRIP, RST_N} = '0;
		CFG_WDATA = 16'h0000;
		MEAS = '0;
		err_total = 0;
		checks = 0;
		repeat (4) @(negedge CLK);
		cmp(CFG_RDATA, 16'h0177);
		RST_N = 1'b1;
		repeat (3) @(negedge CLK);
		cmp(16'({RESERVE_COMP_ENABLE_EN, ADC_GND_ALT, WAKE_SEL, RA_STEP_EN, EXT_TEMP_SEL, SHUTDOWN_EN}), 16'h000F);
		cmp(16'({SD_PIN_OE_N, SD_PIN_OUT}), 16'h0000);
		HIB_REQ = 1'b1;
		wait_mode(pcf_pkg::PM_HIBERNATE);
		HIB_REQ = 1'b0;
		@(negedge CLK);
		cmp(16'(SD_PIN_OE_N), 16'h0001);
		COMM_ACT = 1'b1;
		wait_mode(pcf_pkg::PM_NORMAL);
		COMM_ACT = 1'b0;
		@(negedge CLK) CLEAR_SHUTDOWN = 1'b1;
		@(negedge CLK) CLEAR_SHUTDOWN = 1'b0;
		HIB_REQ = 1'b1;
		wait_mode(pcf_pkg::PM_HIBERNATE);
		HIB_REQ = 1'b0;
		@(negedge CLK);
		cmp(16'({SHUTDOWN_EN, SD_PIN_OE_N, SD_PIN_OUT}), 16'h0000);
		IO_ACT = 1'b1;
		wait_mode(pcf_pkg::PM_NORMAL);
		IO_ACT = 1'b0;
		@(negedge CLK) SET_SHUTDOWN = 1'b1;
		@(negedge CLK) SET_SHUTDOWN = 1'b0;
		repeat (2) @(negedge CLK);
		cmp(16'(SHUTDOWN_EN), 16'h0001);
		// Taper: boundary capacity change, then two qualifying windows
		meas(16'h00FA, 16'h0032, 16'h0000);
		cmp(16'(FLAGS[6:4]), 16'h0001);
		repeat (2) meas(16'h00FA, 16'h0005, 16'h0019);
		cmp(16'(FLAGS[6:4]), 16'h0001);
		meas(16'h00FA, 16'h0005, 16'h001A);
		cmp(16'(FLAGS[6:4]), 16'h0001);
		cmp(16'(load_seen), 16'h0000);
		meas(16'h00FA, 16'h0005, 16'h001A);
		cmp(16'(FLAGS[6:4]), 16'h0006);
		cmp(16'(load_seen), 16'h0001);
		wait_mode(pcf_pkg::PM_SLEEP);
		@(negedge CLK) SENSE_NEG_TRIP = 1'b1;
		@(negedge CLK) SENSE_NEG_TRIP = 1'b0;
		@(negedge CLK);
		cmp(16'(WAKE_EVENT), 16'h0001);
		meas(16'h00FA, 16'h0032, 16'h0000);
		wait_mode(pcf_pkg::PM_NORMAL);
		wr(16'h8800);
		cmp(CFG_RDATA, 16'h8800);
		cmp(16'({RESERVE_COMP_ENABLE_EN, ADC_GND_ALT, WAKE_SEL, RA_STEP_EN, EXT_TEMP_SEL, SHUTDOWN_EN}), 16'h00C0);
		meas(16'h00FA, 16'h0005, 16'h0000);
		repeat (4) @(negedge CLK);
		cmp(16'(MODE), 16'h0000);
		@(negedge CLK) SENSE_POS_TRIP = 1'b1;
		@(negedge CLK) SENSE_POS_TRIP = 1'b0;
		repeat (2) @(negedge CLK);
		cmp(16'(WAKE_EVENT), 16'h0000);
		// Charge over-temperature needs two sets, then recovers
		meas(16'h01CC, 16'h0032, 16'h0000);
		cmp(16'(FLAGS[2:0]), 16'h0004);
		meas(16'h01CC, 16'h0032, 16'h0000);
		cmp(16'(FLAGS[0]), 16'h0001);
		meas(16'h0186, 16'h0032, 16'h0000);
		cmp(16'(FLAGS[0]), 16'h0000);
		repeat (3) meas(16'h0208, 16'hFFCE, 16'h0000);
		cmp(16'(FLAGS[3:1]), 16'h0006);
		meas(16'h0186, 16'h0000, 16'h0000);
		cmp(16'(FLAGS[3:2]), 16'h0003);
		meas(16'h00C8, 16'h0000, 16'h0000);
		cmp(16'(FLAGS[3:2]), 16'h0000);
		meas(16'hFFF6, 16'h0000, 16'h0000);
		cmp(16'(FLAGS[3:2]), 16'h0001);
		meas(16'hFFC4, 16'h0000, 16'h0000);
		cmp(16'(FLAGS[3:2]), 16'h0003);
		final_report();
	end
endmodule
